// ===== hw/led_greyscale_pwm_counter.sv
// Greyscale PWM engine of a sixteen-channel LED sink driver
// Timing and use
// Both pins are asynchronous to ref_clk and pass a three-stage filter.
// A pin change is accepted on the third edge after it, when the second
// and third stages agree; a glitch shorter than that is ignored.
// The count clock therefore needs each phase held for at least two
// system clock cycles, which caps its rate well below the system clock.
// An accepted count rise updates greyCount and sinkChannel one cycle later.
// Brightness levels load in parallel through levelWrite and take effect
// on the next compare; loading while blanked avoids a torn cycle.
// The counter is thirteen bits wide so that count 4096 can be held
// without wrapping back to zero and relighting the channels.
// A channel at level one turns on and off on the same pulse, the
// switch-off winning, so it never lights.
// clkEn low freezes every flip-flop, the filters included, so pin
// activity during a freeze is lost rather than queued.
// Reset treats blanking as asserted until the filter sees the pin low.
`timescale 1ns/1ps
module led_greyscale_pwm_counter
  import led_pwm_pkg::*;
#(
  parameter int unsigned NUM_CH = led_pwm_pkg::CHANNELS
) (
  input  wire logic                 ref_clk,          // System clock, 100 MHz
  input  wire logic                 rst,              // Synchronous reset, active high
  input  wire logic                 clkEn,            // Freezes all state while low
  input  wire logic                 outputBlank,      // Blanking pin, asynchronous
  input  wire logic                 pwmCountClock,    // Count clock pin, asynchronous
  input  wire logic                 levelWrite,       // Load all brightness levels
  input  wire logic [NUM_CH*12-1:0] levelData,        // New levels, channel 0 in low bits
  output logic      [NUM_CH-1:0]    sinkChannel,      // Sink enables, high = on
  output logic      [12:0]          greyCount         // Current greyscale counter
);
  import led_pwm_pkg::*;

  typedef struct packed {
    logic [2:0]           blankSync;
    logic [2:0]           countSync;
    logic                 blankState;
    logic                 countState;
    logic [12:0]          counter;
    logic [NUM_CH-1:0]    sinkOn;
    logic [NUM_CH*12-1:0] level;
  } state_s;

  state_s cur;
  state_s next_cur;

  logic blankNow;
  logic countNow;
  logic countRise;
  logic [12:0] nextCount;

  // Filtered pin levels: change counts once second and third stages agree
  always_comb begin
    blankNow = (cur.blankSync[1] == cur.blankSync[2]) ? cur.blankSync[2] : cur.blankState;
    countNow = (cur.countSync[1] == cur.countSync[2]) ? cur.countSync[2] : cur.countState;
    countRise = countNow && !cur.countState;
    nextCount = cur.counter + 13'h0001;
  end

  // Next-state logic
  // Blanking has priority over counting; a count rise while blanked is dropped,
  // and a rise at the final count is dropped too, so the counter never wraps.
  always_comb begin
    next_cur = cur;
    next_cur.blankSync = {cur.blankSync[1:0], outputBlank};
    next_cur.countSync = {cur.countSync[1:0], pwmCountClock};
    next_cur.blankState = blankNow;
    next_cur.countState = countNow;
    if (levelWrite) begin
      next_cur.level = levelData;
    end
    if (blankNow) begin
      next_cur.counter = COUNT_ZERO;
      next_cur.sinkOn = '0;
    end else if (countRise && cur.counter < FINAL_COUNT) begin
      next_cur.counter = nextCount;
      for (int i = 0; i < NUM_CH; i++) begin
        if (cur.counter == COUNT_ZERO) begin
          next_cur.sinkOn[i] = (cur.level[i*12 +: 12] != 12'h000);
        end
        if ({1'b0, cur.level[i*12 +: 12]} == nextCount) begin
          next_cur.sinkOn[i] = 1'b0;
        end
      end
    end else if (cur.counter >= FINAL_COUNT) begin
      next_cur.sinkOn = '0;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur.blankSync <= 3'h7;
      cur.countSync <= 3'h0;
      cur.blankState <= 1'b1;
      cur.countState <= 1'b0;
      cur.counter <= COUNT_ZERO;
      cur.sinkOn <= '0;
      cur.level <= {NUM_CH{LEVEL_RESET}};
    end else if (clkEn) begin
      cur <= next_cur;
    end
  end

  assign sinkChannel = cur.sinkOn;
  assign greyCount = cur.counter;

  // Assertions
  // These watch the registered outputs, the stored levels and the filtered pin levels.
  // The synchroniser stages are left unchecked, since a pin may glitch
  // freely before the filter accepts it.
  // Channel-specific checks use channel 0 and channel 2, whose levels the
  // bench sets to zero and two.

  a_blank_forces_off: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && blankNow)
      |=> (sinkChannel == '0 && greyCount == COUNT_ZERO))
    else $error("Blanking did not force channels off");

  a_blank_drops_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && blankNow && countRise)
      |=> (greyCount == COUNT_ZERO))
    else $error("Counter moved while blanked");

  a_count_steps_one: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && !blankNow && countRise && cur.counter < FINAL_COUNT)
      |=> (greyCount == $past(greyCount) + 13'h0001))
    else $error("Counter did not step by one");

  a_count_only_rise: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && !countRise)
      |=> (greyCount == $past(greyCount) || greyCount == COUNT_ZERO))
    else $error("Counter moved without a count pulse");

  a_freeze_holds: assert property (@(posedge ref_clk) disable iff (rst)
    (!clkEn)
      |=> (greyCount == $past(greyCount) && sinkChannel == $past(sinkChannel)))
    else $error("State changed while frozen");

  a_no_wrap_past: assert property (@(posedge ref_clk) disable iff (rst)
    (greyCount == FINAL_COUNT && !blankNow)
      |=> (greyCount == FINAL_COUNT || $past(!clkEn)))
    else $error("Counter wrapped past final count");

  a_final_all_off: assert property (@(posedge ref_clk) disable iff (rst)
    (greyCount == FINAL_COUNT)
      |-> (sinkChannel == '0))
    else $error("Channel on after final count");

  a_first_pulse_on: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && !blankNow && countRise && greyCount == COUNT_ZERO && cur.level[11:0] > 12'h001)
      |=> sinkChannel[0])
    else $error("Channel zero not switched on at first pulse");

  a_zero_stays_off: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && !blankNow && countRise && greyCount == COUNT_ZERO && cur.level[11:0] == 12'h000)
      |=> !sinkChannel[0])
    else $error("Zero level channel switched on");

  a_on_needs_count: assert property (@(posedge ref_clk) disable iff (rst)
    (sinkChannel != '0)
      |-> (greyCount != COUNT_ZERO))
    else $error("Channel on while counter at zero");

  a_match_off: assert property (@(posedge ref_clk) disable iff (rst)
    (greyCount != COUNT_ZERO && {1'b0, cur.level[35:24]} == greyCount && $changed(greyCount))
      |-> !sinkChannel[2])
    else $error("Channel not off at matching count");

  a_level_loads: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && levelWrite)
      |=> (cur.level == $past(levelData)))
    else $error("Level load not taken");

  a_reset_full: assert property (@(posedge ref_clk)
    $fell(rst)
      |-> (cur.level[11:0] == LEVEL_RESET))
    else $error("Level not full scale after reset");

  a_clear_on_blank: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && blankNow && greyCount == FINAL_COUNT)
      |=> (greyCount == COUNT_ZERO))
    else $error("Counter not cleared at blanking");

  // Main scenarios reached
  c_full_cycle:   cover property (@(posedge ref_clk) greyCount == FINAL_COUNT);
  c_first_on:     cover property (@(posedge ref_clk) $rose(sinkChannel[0]));
  c_mid_off:      cover property (@(posedge ref_clk) $fell(sinkChannel[2]) && !blankNow);
  c_frozen:       cover property (@(posedge ref_clk) $fell(clkEn));
  c_refused_rise: cover property (@(posedge ref_clk) greyCount == FINAL_COUNT && countRise);
endmodule : led_greyscale_pwm_counter

// ===== inc/led_pwm_pkg.sv
// Constants shared by the greyscale PWM engine
package led_pwm_pkg;
  localparam int unsigned CHANNELS    = 16;
  localparam int unsigned LEVEL_W     = 12;
  localparam logic [11:0] LEVEL_RESET = 12'hfff;
  localparam logic [12:0] FINAL_COUNT = 13'h1000;
  localparam logic [12:0] COUNT_ZERO  = 13'h0000;
endpackage : led_pwm_pkg

// ===== tb/led_greyscale_pwm_counter_tb.sv
// Self-checking bench for the greyscale PWM engine
`timescale 1ns/1ps
module led_greyscale_pwm_counter_tb;
  logic         ref_clk, rst, clkEn, levelWrite, outputBlank, pwmCountClock;
  logic [191:0] levelData;
  logic [15:0]  sinkChannel;
  logic [12:0]  greyCount;
  logic [11:0]  lvl [16];
  int           n_errors = 0;
  int           compares = 0;
  led_greyscale_pwm_counter u_led_greyscale_pwm_counter (.ref_clk(ref_clk), .rst(rst),
    .clkEn(clkEn), .outputBlank(outputBlank), .pwmCountClock(pwmCountClock),
    .levelWrite(levelWrite), .levelData(levelData), .sinkChannel(sinkChannel),
    .greyCount(greyCount));
  pwm_ctrl_model u_pwm_ctrl_model (.ref_clk(ref_clk), .outputBlank(outputBlank),
    .pwmCountClock(pwmCountClock));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Counter and enables expected at count c
  task automatic state(input int c);
    logic [15:0] on;
    @(negedge ref_clk);
    for (int i = 0; i < 16; i++) on[i] = (c > 0) && (c < 4096) && (c < lvl[i]);
    check({3'h0, greyCount}, c[15:0]);
    check(sinkChannel, on);
  endtask : state
  // Verdict and end of run
  task automatic results();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // Default levels after reset
  task automatic t_defaults();
    state(0);
    u_pwm_ctrl_model.blank(1'b0);
    u_pwm_ctrl_model.pulses(1);
    state(1);
    u_pwm_ctrl_model.pulses(1);
    state(2);
    u_pwm_ctrl_model.blank(1'b1);
    state(0);
    $display("test defaults done");
  endtask : t_defaults
  // Boundary levels over a full cycle
  task automatic t_levels();
    lvl[0] = 12'h000;
    lvl[1] = 12'h001;
    lvl[2] = 12'h002;
    @(posedge ref_clk);
    for (int i = 0; i < 16; i++) levelData[i*12 +: 12] <= lvl[i];
    levelWrite <= 1'b1;
    @(posedge ref_clk) levelWrite <= 1'b0;
    u_pwm_ctrl_model.blank(1'b0);
    u_pwm_ctrl_model.pulses(1);
    state(1);
    u_pwm_ctrl_model.pulses(1);
    state(2);
    u_pwm_ctrl_model.pulses(4093);
    state(4095);
    u_pwm_ctrl_model.pulses(3);
    state(4096);
    u_pwm_ctrl_model.blank(1'b1);
    state(0);
    u_pwm_ctrl_model.pulses(1);
    state(0);
    u_pwm_ctrl_model.blank(1'b0);
    u_pwm_ctrl_model.pulses(1);
    state(1);
    $display("test levels done");
  endtask : t_levels
  // Clock enable low freezes counter and filters
  task automatic t_freeze();
    @(posedge ref_clk) clkEn <= 1'b0;
    u_pwm_ctrl_model.pulses(1);
    state(1);
    @(posedge ref_clk) clkEn <= 1'b1;
    u_pwm_ctrl_model.pulses(1);
    state(2);
    u_pwm_ctrl_model.blank(1'b1);
    state(0);
    $display("test freeze done");
  endtask : t_freeze
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Watchdog
  initial begin
    #600us;
    n_errors++;
    results();
  end
  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    levelWrite = 1'b0;
    levelData = '0;
    for (int i = 0; i < 16; i++) lvl[i] = 12'hfff;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_defaults();
    t_levels();
    t_freeze();
    results();
  end
endmodule : led_greyscale_pwm_counter_tb

// ===== tb/pwm_ctrl_model.sv
// Display controller model: drives blanking and count clock
`timescale 1ns/1ps
module pwm_ctrl_model (
  input  wire logic ref_clk,      // System clock
  output logic      outputBlank,  // Blanking drive, high = blank
  output logic      pwmCountClock // Count clock, low between frames
);
  initial outputBlank = 1'b1;
  initial pwmCountClock = 1'b0;
  // levels load in parallel, so no serial shift clock is needed
  task automatic blank(input logic v);
    @(posedge ref_clk) outputBlank <= v;
    repeat (6) @(posedge ref_clk);
  endtask : blank
  // pulse train, four cycles high and five low
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge ref_clk) pwmCountClock <= 1'b1;
      repeat (4) @(posedge ref_clk);
      pwmCountClock <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask : pulses
endmodule : pwm_ctrl_model
